/* File: design/bfc_pkg.sv */
// Package: register map, field layout and fade timing constants for the backlight fade block
//
// Overview of operation
// R1: Fade register upper nibble sets fade-out time
// R2: Rate code zero still ramps within 100 ms
// R3: Fade-out ramps down to dim or off
// R4: Fade-out time is for full 30-0 mA
// R5: Lower nibble sets fade-in time, same table
// R6: Turn-on ramps current up to selected maximum
// R7: Fade-in time is for full 0-30 mA
// R8: Level 1 maximum is 7-bit, bit 7 reserved
// R9: Linear law: 0.236 mA per code step
// R10: Square law: 30 mA times (code/127) squared
// R11: Cubic laws: square DAC, varied step time
// R12: Level 1 dim code applied after dim timeout
// R13: Level 2 maximum register at index 0x0B
// R14: Dim-force flag also applies the dim code
// R15: Two-bit level field selects currents; 11 off
// R16: Two-bit law field selects transfer law
// R17: Ramp moves one code per step interval
package bfc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONFIG = 6'h04;
  localparam logic [5:0] IDX_FADE_RATES = 6'h08;
  localparam logic [5:0] IDX_L1_MAX = 6'h09;
  localparam logic [5:0] IDX_L1_DIM = 6'h0a;
  localparam logic [5:0] IDX_L2_MAX = 6'h0b;
  localparam logic [5:0] IDX_L2_DIM = 6'h0c;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;

  // Reset values of the writable registers
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_FADE_RATES = 8'h00;
  localparam logic [6:0] RST_CODE = 7'h00;
  localparam logic [1:0] RST_CONTROL = 2'h0;

  // Field positions
  localparam int FO_MSB = 7;
  localparam int FO_LSB = 4;
  localparam int FI_MSB = 3;
  localparam int FI_LSB = 0;
  localparam int CODE_MSB = 6;
  localparam int LVL_MSB = 4;
  localparam int LVL_LSB = 3;
  localparam int LAW_MSB = 2;
  localparam int LAW_LSB = 1;
  localparam int CTL_ON_BIT = 0;
  localparam int CTL_DIM_FORCE_BIT = 1;
  localparam int ST_FADING_BIT = 7;
  localparam int ST_DIM_BIT = 8;
  localparam int CUBIC_SEL_BIT = 6;

  // DAC code range
  localparam int DAC_W = 7;
  localparam logic [6:0] DAC_ZERO = 7'h00;
  localparam int DAC_STEPS = 127;

  // Brightness level and transfer law encodings
  typedef enum logic [1:0] {
    BFC_LVL_DAYLIGHT = 2'h0,
    BFC_LVL_OFFICE = 2'h1,
    BFC_LVL_DARK = 2'h2,
    BFC_LVL_OFF = 2'h3
  } bfc_level_t;

  typedef enum logic [1:0] {
    BFC_LAW_LINEAR = 2'h0,
    BFC_LAW_SQUARE = 2'h1,
    BFC_LAW_CUBIC10 = 2'h2,
    BFC_LAW_CUBIC11 = 2'h3
  } bfc_law_t;

  // Timing: full-scale fade durations are whole multiples of this unit
  localparam int CLK_MHZ = 100;
  localparam int FADE_UNIT_MS = 100;
  localparam int STEP_TICK_CYC = FADE_UNIT_MS * 1000 * CLK_MHZ / DAC_STEPS;

  // Full-scale duration in fade units per rate code; code 0 is the fast 100 ms ramp
  typedef logic [5:0] bfc_units_t;
  localparam bfc_units_t FADE_UNITS [16] = '{
    6'h01, 6'h03, 6'h06, 6'h09, 6'h0c, 6'h0f, 6'h12, 6'h15,
    6'h18, 6'h1b, 6'h1e, 6'h23, 6'h28, 6'h2d, 6'h32, 6'h37
  };

endpackage

/* File: design/bfc_tick_if.sv */
// Interface: step period and tick between the fade engine and its step timer
`timescale 1ns/1ps
interface bfc_tick_if #(
  parameter int W = 32
);
  logic [W-1:0] period;
  logic run;
  logic tick;

  modport engine (output period, output run, input tick);
  modport timer (input period, input run, output tick);
endinterface

/* File: design/bfc_step_timer.sv */
// Step timer: one-cycle tick every period cycles while running
`timescale 1ns/1ps
module bfc_step_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  bfc_tick_if.timer t
);

  logic [W-1:0] cnt_q;

  // Count restarts whenever the ramp stops, so each ramp begins with a full interval
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      t.tick <= 1'b0;
    end else if (ce) begin
      t.tick <= 1'b0;
      if (!t.run) begin
        cnt_q <= '0;
      end else if (cnt_q + W'(1) >= t.period) begin
        cnt_q <= '0;
        t.tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

endmodule

/* File: design/bfc_fade_top.sv */
// Backlight fade engine with per-level current codes behind an APB slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module bfc_fade_top #(
  parameter int ADDR_W = 8,
  parameter int TICK_CYC = bfc_pkg::STEP_TICK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dim_timeout_expired,
  output logic [6:0] dac_code,
  output logic square_law,
  output logic fading
);

  // Software-visible registers
  logic [7:0] config_q;
  logic [7:0] fade_rates_q;
  logic [6:0] level1_max_current_q;
  logic [6:0] level1_dim_current_q;
  logic [6:0] level2_max_current_q;
  logic [6:0] level2_dim_current_q;
  logic [1:0] control_q;

  // Engine state
  logic [6:0] dac_q;
  logic [6:0] target_d;
  logic [6:0] sel_max;
  logic [6:0] sel_dim;
  logic dim_active;
  logic bl_on;
  logic ramp_up;
  logic [3:0] rate_code;
  logic [31:0] period_d;
  bfc_pkg::bfc_level_t level;
  bfc_pkg::bfc_law_t law;

  // APB decode
  logic access;
  logic wr_en;
  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic [31:0] rd_d;

  bfc_tick_if #(.W(32)) tick_if ();

  bfc_step_timer #(.W(32)) u_timer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .t(tick_if)
  );

  // Field views of the configuration and control registers
  assign level = bfc_pkg::bfc_level_t'(config_q[bfc_pkg::LVL_MSB:bfc_pkg::LVL_LSB]); // [R15]
  assign law = bfc_pkg::bfc_law_t'(config_q[bfc_pkg::LAW_MSB:bfc_pkg::LAW_LSB]); // [R16]
  assign bl_on = control_q[bfc_pkg::CTL_ON_BIT];
  assign dim_active = control_q[bfc_pkg::CTL_DIM_FORCE_BIT] | dim_timeout_expired; // [R12] [R14]

  // Level selects the code pair; dark shares level 1 codes as no level 3 pair exists here
  always_comb begin
    case (level)
      bfc_pkg::BFC_LVL_OFFICE: begin
        sel_max = level2_max_current_q; // [R13] [R15]
        sel_dim = level2_dim_current_q;
      end
      bfc_pkg::BFC_LVL_OFF: begin
        sel_max = bfc_pkg::DAC_ZERO; // [R15]
        sel_dim = bfc_pkg::DAC_ZERO;
      end
      default: begin
        sel_max = level1_max_current_q; // [R15]
        sel_dim = level1_dim_current_q;
      end
    endcase
  end

  // Target: off when switched off, dim code when dimmed, maximum otherwise
  always_comb begin
    if (!bl_on) begin
      target_d = bfc_pkg::DAC_ZERO; // [R3]
    end else if (dim_active) begin
      target_d = sel_dim; // [R3] [R12] [R14]
    end else begin
      target_d = sel_max; // [R6]
    end
  end

  // Rising ramps use the fade-in code, falling ramps the fade-out code
  assign ramp_up = target_d > dac_q;
  assign rate_code = ramp_up ? fade_rates_q[bfc_pkg::FI_MSB:bfc_pkg::FI_LSB] // [R5]
                             : fade_rates_q[bfc_pkg::FO_MSB:bfc_pkg::FO_LSB]; // [R1]

  // Per-code interval is full-scale time over 127 steps, so shorter ramps end sooner.
  // Cubic laws double the dwell on one half of the range and halve it on the other.
  always_comb begin
    logic [31:0] base;
    base = 32'(bfc_pkg::FADE_UNITS[rate_code]) * 32'(TICK_CYC); // [R1] [R2] [R4] [R5] [R7] [R17]
    case (law)
      bfc_pkg::BFC_LAW_CUBIC10: begin
        period_d = dac_q[bfc_pkg::CUBIC_SEL_BIT] ? (base >> 1) : (base << 1); // [R11]
      end
      bfc_pkg::BFC_LAW_CUBIC11: begin
        period_d = dac_q[bfc_pkg::CUBIC_SEL_BIT] ? (base << 1) : (base >> 1); // [R11]
      end
      default: begin
        period_d = base; // [R9] [R10]
      end
    endcase
    if (period_d == '0) begin
      period_d = 32'h0000_0001;
    end
  end

  assign tick_if.period = period_d;
  assign tick_if.run = target_d != dac_q;

  // One code per tick toward the target; a moving target just changes direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac_q <= bfc_pkg::DAC_ZERO;
    end else if (ce && tick_if.tick) begin
      if (target_d > dac_q) begin
        dac_q <= dac_q + 7'h01; // [R6] [R17]
      end else if (target_d < dac_q) begin
        dac_q <= dac_q - 7'h01; // [R3] [R17]
      end
    end
  end

  // Registered outputs toward the current sinks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac_code <= bfc_pkg::DAC_ZERO;
      square_law <= 1'b0;
      fading <= 1'b0;
    end else if (ce) begin
      dac_code <= dac_q;
      square_law <= law != bfc_pkg::BFC_LAW_LINEAR; // [R9] [R10] [R11]
      fading <= target_d != dac_q;
    end
  end

  // APB: access phase taken once, answered with one wait state
  assign access = psel && penable && !pready;
  assign wr_en = access && pwrite && pstrb[0] && mapped && ce;
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:2] == (ADDR_W-2)'(idx));

  always_comb begin
    mapped = aligned;
    rd_d = 32'h0000_0000;
    case (idx)
      bfc_pkg::IDX_CONFIG: rd_d[7:0] = config_q;
      bfc_pkg::IDX_FADE_RATES: rd_d[7:0] = fade_rates_q;
      bfc_pkg::IDX_L1_MAX: rd_d[6:0] = level1_max_current_q; // [R8]
      bfc_pkg::IDX_L1_DIM: rd_d[6:0] = level1_dim_current_q;
      bfc_pkg::IDX_L2_MAX: rd_d[6:0] = level2_max_current_q; // [R13]
      bfc_pkg::IDX_L2_DIM: rd_d[6:0] = level2_dim_current_q;
      bfc_pkg::IDX_CONTROL: rd_d[1:0] = control_q;
      bfc_pkg::IDX_STATUS: begin
        rd_d[6:0] = dac_q;
        rd_d[bfc_pkg::ST_FADING_BIT] = target_d != dac_q;
        rd_d[bfc_pkg::ST_DIM_BIT] = dim_active;
      end
      default: mapped = 1'b0;
    endcase
    if (!aligned) begin
      rd_d = 32'h0000_0000;
    end
  end

  // Answer phase; status is read-only so writes to it are quietly dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= access;
      pslverr <= access && !mapped;
      if (access && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // Configuration, fade rate and control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      config_q <= bfc_pkg::RST_CONFIG;
      fade_rates_q <= bfc_pkg::RST_FADE_RATES;
      control_q <= bfc_pkg::RST_CONTROL;
    end else if (wr_en) begin
      case (idx)
        bfc_pkg::IDX_CONFIG: config_q <= {3'h0, pwdata[4:1], 1'b0};
        bfc_pkg::IDX_FADE_RATES: fade_rates_q <= pwdata[7:0]; // [R1] [R5]
        bfc_pkg::IDX_CONTROL: control_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Current codes; bit 7 is reserved and reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level1_max_current_q <= bfc_pkg::RST_CODE;
      level1_dim_current_q <= bfc_pkg::RST_CODE;
      level2_max_current_q <= bfc_pkg::RST_CODE;
      level2_dim_current_q <= bfc_pkg::RST_CODE;
    end else if (wr_en) begin
      case (idx)
        bfc_pkg::IDX_L1_MAX: level1_max_current_q <= pwdata[bfc_pkg::CODE_MSB:0]; // [R8]
        bfc_pkg::IDX_L1_DIM: level1_dim_current_q <= pwdata[bfc_pkg::CODE_MSB:0]; // [R12]
        bfc_pkg::IDX_L2_MAX: level2_max_current_q <= pwdata[bfc_pkg::CODE_MSB:0]; // [R13]
        bfc_pkg::IDX_L2_DIM: level2_dim_current_q <= pwdata[bfc_pkg::CODE_MSB:0];
        default: ;
      endcase
    end
  end

endmodule

/* File: bench/bfc_fade_props.sv */
// Checker: bus handshake and fade stepping properties of the fade top
`timescale 1ns/1ps
module bfc_fade_props #(
  parameter int ADDR_W = 8,
  parameter int TICK_CYC = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] dac_code,
  input wire logic fading
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Access phase still waiting for its answer
  sequence s_acc;
    psel && penable && !pready && ce;
  endsequence
  // Current code has just moved
  sequence s_step;
    $changed(dac_code);
  endsequence
  answer_wait_a: assert property (s_acc |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error alone");
  // Writes leave the read data alone, so only a misaligned read must show zero
  misalign_err_a: assert property ((s_acc ##0 paddr[1:0] != 2'h0 && !pwrite) |=> pslverr && prdata == 32'h0)
    else $error("misaligned accepted");
  one_code_a: assert property (s_step |-> dac_code == $past(dac_code) + 7'h01
    || dac_code == $past(dac_code) - 7'h01) else $error("code jumped");
  step_space_a: assert property (s_step |=> $stable(dac_code)) else $error("steps too close");
  step_flag_a: assert property (s_step |-> $past(fading)) else $error("step while idle");
  hold_done_a: assert property (!fading |=> $stable(dac_code)) else $error("code moved");
endmodule
bind bfc_fade_top bfc_fade_props #(.ADDR_W(ADDR_W), .TICK_CYC(TICK_CYC)) i_props (.clk, .nrst,
  .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .dac_code, .fading);

/* File: bench/bfc_sink_model.sv */
// Sink model: current drawn by the backlight sinks for a DAC code
`timescale 1ns/1ps
module bfc_sink_model (
  input wire logic [6:0] dac_code,
  input wire logic square_law,
  output int current_ua
);
  // Microamps; truncation keeps the bench figures exact integers
  always_comb begin
    if (square_law) current_ua = 30000 * int'(dac_code) * int'(dac_code) / 16129;
    else current_ua = 30000 * int'(dac_code) / 127;
  end
endmodule

/* File: bench/backlight_fade_current_levels_tb.sv */
// Testbench: register access and fade timing of the backlight fade block
`timescale 1ns/1ps
module backlight_fade_current_levels_tb;
  localparam int TK = 4;
  localparam logic [5:0] CFG = bfc_pkg::IDX_CONFIG;
  localparam logic [5:0] FR = bfc_pkg::IDX_FADE_RATES;
  localparam logic [5:0] MX1 = bfc_pkg::IDX_L1_MAX;
  localparam logic [5:0] DM1 = bfc_pkg::IDX_L1_DIM;
  localparam logic [5:0] MX2 = bfc_pkg::IDX_L2_MAX;
  localparam logic [5:0] CTL = bfc_pkg::IDX_CONTROL;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, dim_to = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, square_law, fading, ev;
  logic [6:0] dac_code, hold;
  logic ce = 1'b1;
  logic [5:0] idx [7] = '{CFG, FR, MX1, DM1, MX2, bfc_pkg::IDX_L2_DIM, CTL};
  int fic [3] = '{0, 1, 15};
  int err_total = 0, checks_done = 0, ua, n;
  // Strobes tied: partial writes are not exercised; clock enable is driven for a freeze test
  bfc_fade_top #(.TICK_CYC(TK)) i_dut (.clk, .nrst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .dim_timeout_expired(dim_to),
    .dac_code, .square_law, .fading);
  bfc_sink_model i_sink (.dac_code, .square_law, .current_ua(ua));
  initial forever #5 clk = ~clk;
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task summarize();
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [5:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  task rd(input logic [5:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    cmp(rv, e);
  endtask
  // Cycles until the code next moves, bounded
  task wchg();
    logic [6:0] p;
    p = dac_code;
    n = 0;
    while (dac_code === p && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task gap(input int e);
    wchg();
    wchg();
    cmp(n, e);
  endtask
  task land(input logic [6:0] e);
    n = 0;
    while (dac_code !== e && n < 40000) begin
      @(posedge clk);
      n++;
    end
    cmp(dac_code, e);
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #500000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (idx[i]) rd(idx[i], 32'h0);
    wr(MX1, 32'hff);
    rd(MX1, 32'h7f);
    wr(DM1, 32'hff);
    rd(DM1, 32'h7f);
    wr(MX2, 32'h2a);
    rd(MX2, 32'h2a);
    wr(FR, 32'ha5);
    rd(FR, 32'ha5);
    apb(1'b0, 8'h80, 32'h0);
    cmp(ev, 1'b1);
    apb(1'b0, 8'h81, 32'h0);
    cmp(ev, 1'b1);
    for (int l = 0; l < 4; l++) begin
      wr(CFG, l << 1);
      @(posedge clk);
      cmp(square_law, l != 0);
    end
    wr(CFG, 32'h0);
    foreach (fic[k]) begin
      wr(FR, fic[k]);
      wr(CTL, 32'h1);
      gap(bfc_pkg::FADE_UNITS[fic[k]] * TK);
      wr(FR, 32'h0);
      wr(CTL, 32'h0);
      land(7'h00);
    end
    wr(FR, 32'h31);
    wr(CTL, 32'h1);
    // Freeze mid-ramp with no transfer in flight: the code must not move
    repeat (30) @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    hold = dac_code;
    repeat (40) @(posedge clk);
    cmp(dac_code, hold);
    ce <= 1'b1;
    land(7'h7f);
    cmp(ua, 30000);
    wr(DM1, 32'h40);
    wr(CTL, 32'h3);
    gap(bfc_pkg::FADE_UNITS[3] * TK);
    land(7'h40);
    cmp(ua, 64 * 30000 / 127);
    wr(CFG, 32'h2);
    @(posedge clk);
    cmp(ua, 30000 * 64 * 64 / (127 * 127));
    wr(CFG, 32'h0);
    wr(FR, 32'h0);
    wr(CTL, 32'h1);
    land(7'h7f);
    dim_to <= 1'b1;
    land(7'h40);
    wr(DM1, 32'h10);
    land(7'h10);
    wr(CFG, 32'h4);
    dim_to <= 1'b0;
    gap(2 * TK);
    land(7'h7f);
    wr(CFG, 32'h6);
    dim_to <= 1'b1;
    gap(2 * TK);
    land(7'h10);
    dim_to <= 1'b0;
    gap(TK / 2);
    land(7'h7f);
    wr(CFG, 32'h8);
    land(7'h2a);
    wr(CFG, 32'h18);
    land(7'h00);
    wr(CFG, 32'h0);
    repeat (20) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    cmp(dac_code, 7'h00);
    nrst <= 1'b1;
    rd(MX1, 32'h0);
    summarize();
  end
endmodule
